// *** rtl/pil_pkg.sv ***
// constants, register map and state types for the prioritized interrupt logic
package pil_pkg;

  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 21;
  localparam int unsigned STACK_N = 8;
  localparam int unsigned SP_W    = 4;

  // register offsets
  localparam logic [3:0] OFS_CTL_MAIN   = 4'h0;
  localparam logic [3:0] OFS_CTL_SECOND = 4'h1;
  localparam logic [3:0] OFS_CTL_THIRD  = 4'h2;
  localparam logic [3:0] OFS_PRIO_TWO   = 4'h3;
  localparam logic [3:0] OFS_PRIO_THREE = 4'h4;
  localparam logic [3:0] OFS_RESET_CTL  = 4'h5;
  localparam logic [3:0] OFS_TMR0_LO    = 4'h6;
  localparam logic [3:0] OFS_TMR0_HI    = 4'h7;
  localparam logic [3:0] OFS_TMR0_CTL   = 4'h8;

  // irq_control_main fields
  localparam int unsigned MAIN_GIE_BIT    = 7;
  localparam int unsigned MAIN_PERIPHERAL_IRQ_ENABLE_BIT   = 6;
  localparam int unsigned MAIN_T0IE_BIT   = 5;
  localparam int unsigned MAIN_INT0IE_BIT = 4;
  localparam int unsigned MAIN_PORTB_CHANGE_ENABLE_BIT   = 3;
  localparam int unsigned MAIN_T0IF_BIT   = 2;
  localparam int unsigned MAIN_INT0IF_BIT = 1;
  localparam int unsigned MAIN_PORTB_CHANGE_FLAG_BIT   = 0;

  // irq_control_second fields
  localparam int unsigned SEC_EDGE0_BIT  = 3;
  localparam int unsigned SEC_T0IP_BIT   = 2;
  localparam int unsigned SEC_EXT_IRQ3_PRIORITY_BIT = 1;
  localparam int unsigned SEC_PORTB_CHANGE_PRIORITY_BIT   = 0;

  // irq_control_third fields
  localparam int unsigned THR_EXT_IRQ2_PRIORITY_BIT = 7;
  localparam int unsigned THR_EXT_IRQ1_PRIORITY_BIT = 6;
  localparam int unsigned THR_IE1_BIT    = 3;
  localparam int unsigned THR_IF1_BIT    = 0;

  // reset_cause_control fields
  localparam int unsigned RC_PRIORITY_LEVELS_ENABLE_BIT = 7;
  localparam int unsigned RC_CM_BIT   = 5;
  localparam int unsigned RC_RI_BIT   = 4;
  localparam int unsigned RC_TO_BIT   = 3;
  localparam int unsigned RC_PD_BIT   = 2;
  localparam int unsigned RC_POR_BIT  = 1;
  localparam int unsigned RC_BOR_BIT  = 0;

  // timer0 control fields
  localparam int unsigned T0_RUN_BIT   = 7;
  localparam int unsigned T0_EIGHT_BIT = 6;

  // implemented bits, write masks and reset values
  localparam logic [7:0] PRIO_TWO_MASK   = 8'hce;
  localparam logic [7:0] PRIO_THREE_MASK = 8'h36;
  localparam logic [7:0] PRIO_THREE_WR   = 8'h06;
  localparam logic [7:0] RC_MASK         = 8'hbf;
  localparam logic [7:0] RC_WR_MASK      = 8'hb3;
  localparam logic [7:0] RC_RESET        = 8'h3c;
  localparam logic [7:0] T0_CTL_RESET    = 8'h40;
  localparam logic [7:0] ZERO8           = 8'h00;

  typedef struct packed {
    logic [7:0]                    ctl_main;
    logic [7:0]                    ctl_second;
    logic [7:0]                    ctl_third;
    logic [7:0]                    prio_two;
    logic [7:0]                    prio_three;
    logic [7:0]                    reset_ctl;
    logic [7:0]                    tmr_lo;
    logic [7:0]                    tmr_hi;
    logic [7:0]                    tmr_ctl;
    logic [3:0]                    ext_prev;
    logic [3:0]                    rb_prev;
    logic                          asleep;
    logic [3:0]                    wake_en;
    logic                          wake;
    logic                          svc_high;
    logic                          svc_low;
    logic                          irq_high;
    logic                          irq_low;
    logic [7:0]                    rdata;
    logic [SP_W-1:0]               sp;
    logic [STACK_N-1:0][PC_W-1:0]  stack;
    logic [PC_W-1:0]               top;
    logic [7:0]                    sh_working_register;
    logic [7:0]                    sh_status;
    logic [7:0]                    sh_bsr;
  } pil_state_t;

endpackage

// *** rtl/pil_irq.sv ***
// prioritized interrupt logic: sources, priorities, reset causes and entry context
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps

// Behaviour
// - second priority register: osc fail, comparator, bus collision, low voltage, timer3
// - third priority register: serial2 rx/tx, capcomp2, capcomp1; rx/tx are fixed high
// - implemented peripheral priority bits reset to one; unimplemented bits read zero
// - reset-control bit 7 enables two priority levels; clear by default
// - reset-control holds mismatch, reset instr, watchdog, power-down, power-on, brown-out
// - external pins are edge triggered; select bit one is rising, zero falling
// - a selected edge on an external pin sets its flag
// - cleared enable suppresses the request though the flag still sets
// - external interrupt wakes from sleep if its enable was set beforehand
// - after wake high requests need the global enable, low requests the peripheral enable (main bit 6)
// - ext irq 1,2,3 priorities from third bits 6,7 and second bit 1
// - external interrupt zero has no priority bit and is always high
// - eight-bit timer0 sets its flag on rollover from ff to 00
// - sixteen-bit timer0 sets its flag on rollover from ffff to 0000
// - timer0 enabled by main bit 5, priority from second bit 2
// - port b pins 7..4 change sets main bit 0; enable bit 3, priority bit 0
// - interrupt entry pushes the return pc onto the hardware stack while it holds fewer than eight entries
// - interrupt entry copies working, status and bank select into shadows
// - without priority levels peripherals also need the peripheral enable
// - priority bits only matter while priority levels are enabled
module pil_irq
  import pil_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [pil_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pil_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [pil_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [3:0]                ext_pin,
  input  wire logic [3:0]                portb_high_in,
  input  wire logic [7:0]                periph_pend_two,
  input  wire logic [7:0]                periph_pend_three,
  input  wire logic                      sleep_enter,
  input  wire logic                      wdt_expire,
  input  wire logic                      wdt_clear,
  input  wire logic                      reset_instr,
  input  wire logic                      irq_ack,
  input  wire logic                      irq_ack_high,
  input  wire logic [pil_pkg::PC_W-1:0]   ack_return_pc,
  input  wire logic [7:0]                ack_working_register,
  input  wire logic [7:0]                ack_status,
  input  wire logic [7:0]                ack_bank_select_reg,
  input  wire logic                      irq_return,
  output logic                           irq_high_req,
  output logic                           irq_low_req,
  output logic                           wake_pulse,
  output logic      [pil_pkg::PC_W-1:0]   stack_top,
  output logic      [pil_pkg::SP_W-1:0]   stack_depth,
  output logic      [7:0]                shadow_working_register,
  output logic      [7:0]                shadow_status,
  output logic      [7:0]                shadow_bank_select_reg
);
  import pil_pkg::*;

  pil_state_t s_q;
  pil_state_t s_d;

  logic [3:0]  ext_rise;
  logic [3:0]  ext_fall;
  logic [3:0]  ext_event;
  logic [3:0]  ext_flag_q;
  logic [3:0]  ext_en_q;
  logic        rb_change;
  logic        t0_overflow;
  logic [7:0]  t0_lo_next;
  logic [15:0] t0_pair_next;
  logic [5:0]  core_pend;
  logic [5:0]  core_prio;
  logic [15:0] per_pend;
  logic [15:0] per_prio;
  logic        priority_levels_enable;
  logic        any_high;
  logic        any_low;
  logic        any_single;
  logic        wr_main;
  logic        wr_third;
  logic        wr_second;
  logic        wr_prio_two;
  logic        wr_prio_three;
  logic        wr_rc;
  logic        wr_t0_lo;
  logic        wr_t0_hi;
  logic        wr_t0_ctl;

  // edge detection against last sampled pin level
  always_comb
  begin
    ext_rise  = ext_pin & ~s_q.ext_prev;
    ext_fall  = ~ext_pin & s_q.ext_prev;
    rb_change = |(portb_high_in ^ s_q.rb_prev);
  end

  // one select bit per pin picks the edge
  for (genvar g = 0; g < 4; g++)
  begin : g_edge_sel
    assign ext_event[g] = s_q.ctl_second[SEC_EDGE0_BIT + g] ? ext_rise[g] : ext_fall[g];
  end

  // timer0 rollover, eight or sixteen bit
  always_comb
  begin
    t0_lo_next   = s_q.tmr_lo + 8'h01;
    t0_pair_next = {s_q.tmr_hi, s_q.tmr_lo} + 16'h0001;
    t0_overflow  = 1'b0;
    if (s_q.tmr_ctl[T0_RUN_BIT])
    begin
      if (s_q.tmr_ctl[T0_EIGHT_BIT])
      begin
        t0_overflow = (s_q.tmr_lo == 8'hff);
      end
      else
      begin
        t0_overflow = ({s_q.tmr_hi, s_q.tmr_lo} == 16'hffff);
      end
    end
  end

  // request evaluation from registered state and the peripheral pending inputs
  always_comb
  begin
    priority_levels_enable       = s_q.reset_ctl[RC_PRIORITY_LEVELS_ENABLE_BIT];
    ext_flag_q = {s_q.ctl_third[THR_IF1_BIT +: 3], s_q.ctl_main[MAIN_INT0IF_BIT]};
    ext_en_q   = {s_q.ctl_third[THR_IE1_BIT +: 3], s_q.ctl_main[MAIN_INT0IE_BIT]};
    core_pend  = {s_q.ctl_main[MAIN_PORTB_CHANGE_FLAG_BIT] & s_q.ctl_main[MAIN_PORTB_CHANGE_ENABLE_BIT],
                  s_q.ctl_main[MAIN_T0IF_BIT] & s_q.ctl_main[MAIN_T0IE_BIT],
                  ext_flag_q & ext_en_q};
    core_prio  = {s_q.ctl_second[SEC_PORTB_CHANGE_PRIORITY_BIT],
                  s_q.ctl_second[SEC_T0IP_BIT],
                  s_q.ctl_second[SEC_EXT_IRQ3_PRIORITY_BIT],
                  s_q.ctl_third[THR_EXT_IRQ2_PRIORITY_BIT],
                  s_q.ctl_third[THR_EXT_IRQ1_PRIORITY_BIT],
                  1'b1};
    per_pend   = {periph_pend_three & PRIO_THREE_MASK, periph_pend_two & PRIO_TWO_MASK};
    per_prio   = {s_q.prio_three, s_q.prio_two};
    any_high   = |(core_pend & core_prio) | |(per_pend & per_prio);
    any_low    = |(core_pend & ~core_prio) | |(per_pend & ~per_prio);
    any_single = |core_pend | (s_q.ctl_main[MAIN_PERIPHERAL_IRQ_ENABLE_BIT] & |per_pend);
  end

  always_comb
  begin
    s_d           = s_q;
    wr_main       = reg_write && (reg_addr == OFS_CTL_MAIN);
    wr_second     = reg_write && (reg_addr == OFS_CTL_SECOND);
    wr_third      = reg_write && (reg_addr == OFS_CTL_THIRD);
    wr_prio_two   = reg_write && (reg_addr == OFS_PRIO_TWO);
    wr_prio_three = reg_write && (reg_addr == OFS_PRIO_THREE);
    wr_rc         = reg_write && (reg_addr == OFS_RESET_CTL);
    wr_t0_lo      = reg_write && (reg_addr == OFS_TMR0_LO);
    wr_t0_hi      = reg_write && (reg_addr == OFS_TMR0_HI);
    wr_t0_ctl     = reg_write && (reg_addr == OFS_TMR0_CTL);

    s_d.ext_prev = ext_pin;
    s_d.rb_prev  = portb_high_in;
    s_d.wake     = 1'b0;

    // register writes
    if (wr_main)
    begin
      s_d.ctl_main = reg_wdata;
    end
    if (wr_second)
    begin
      s_d.ctl_second = reg_wdata;
    end
    if (wr_third)
    begin
      s_d.ctl_third = reg_wdata;
    end
    if (wr_prio_two)
    begin
      s_d.prio_two = reg_wdata & PRIO_TWO_MASK;
    end
    if (wr_prio_three)
    begin
      // receive/transmit priorities are read-only and stay high
      s_d.prio_three = (reg_wdata & PRIO_THREE_WR) | (s_q.prio_three & ~PRIO_THREE_WR);
    end
    if (wr_rc)
    begin
      s_d.reset_ctl = (reg_wdata & RC_WR_MASK) | (s_q.reset_ctl & ~RC_WR_MASK);
    end
    if (wr_t0_ctl)
    begin
      s_d.tmr_ctl = reg_wdata;
    end

    // timer0 count; a software load wins over the count in that cycle
    if (s_q.tmr_ctl[T0_RUN_BIT])
    begin
      if (s_q.tmr_ctl[T0_EIGHT_BIT])
      begin
        s_d.tmr_lo = t0_lo_next;
      end
      else
      begin
        s_d.tmr_lo = t0_pair_next[7:0];
        s_d.tmr_hi = t0_pair_next[15:8];
      end
    end
    if (wr_t0_lo)
    begin
      s_d.tmr_lo = reg_wdata;
    end
    if (wr_t0_hi)
    begin
      s_d.tmr_hi = reg_wdata;
    end

    // hardware sets flags after the write so a set beats a clear
    if (ext_event[0])
    begin
      s_d.ctl_main[MAIN_INT0IF_BIT] = 1'b1;
    end
    for (int i = 1; i < 4; i++)
    begin
      if (ext_event[i])
      begin
        s_d.ctl_third[THR_IF1_BIT + i - 1] = 1'b1;
      end
    end
    if (t0_overflow)
    begin
      s_d.ctl_main[MAIN_T0IF_BIT] = 1'b1;
    end
    if (rb_change)
    begin
      s_d.ctl_main[MAIN_PORTB_CHANGE_FLAG_BIT] = 1'b1;
    end

    // reset-cause flags driven by the core's events
    if (wdt_clear)
    begin
      s_d.reset_ctl[RC_TO_BIT] = 1'b1;
      s_d.reset_ctl[RC_PD_BIT] = 1'b1;
    end
    if (wdt_expire)
    begin
      s_d.reset_ctl[RC_TO_BIT] = 1'b0;
    end
    if (reset_instr)
    begin
      s_d.reset_ctl[RC_RI_BIT] = 1'b0;
    end

    // sleep entry latches enables; only those enabled before sleep may wake
    if (sleep_enter)
    begin
      s_d.asleep               = 1'b1;
      s_d.wake_en              = ext_en_q;
      s_d.reset_ctl[RC_PD_BIT] = 1'b0;
    end
    else if (s_q.asleep && |(ext_event & s_q.wake_en))
    begin
      s_d.asleep = 1'b0;
      s_d.wake   = 1'b1;
    end

    // request lines; the high request gates on the global enable, the low request on the peripheral enable
    if (priority_levels_enable)
    begin
      s_d.irq_high = s_q.ctl_main[MAIN_GIE_BIT] & any_high & ~s_q.svc_high;
      s_d.irq_low  = s_q.ctl_main[MAIN_PERIPHERAL_IRQ_ENABLE_BIT] & any_low
                     & ~s_q.svc_high & ~s_q.svc_low;
    end
    else
    begin
      s_d.irq_high = s_q.ctl_main[MAIN_GIE_BIT] & any_single
                     & ~s_q.svc_high & ~s_q.svc_low;
      s_d.irq_low  = 1'b0;
    end

    // interrupt entry: push return pc and take fast shadows
    if (irq_ack)
    begin
      if (irq_ack_high || !priority_levels_enable)
      begin
        s_d.svc_high = 1'b1;
      end
      else
      begin
        s_d.svc_low = 1'b1;
      end
      s_d.irq_high  = 1'b0;
      s_d.irq_low   = 1'b0;
      s_d.sh_working_register   = ack_working_register;
      s_d.sh_status = ack_status;
      s_d.sh_bsr    = ack_bank_select_reg;
      s_d.top       = ack_return_pc;
      // a full stack keeps its deepest entries and drops the newest push
      if (s_q.sp < SP_W'(STACK_N))
      begin
        s_d.stack[s_q.sp[2:0]] = ack_return_pc;
        s_d.sp                 = s_q.sp + 4'h1;
      end
    end
    else if (irq_return)
    begin
      if (s_q.svc_high)
      begin
        s_d.svc_high = 1'b0;
      end
      else
      begin
        s_d.svc_low = 1'b0;
      end
      if (s_q.sp > 4'h1)
      begin
        s_d.sp  = s_q.sp - 4'h1;
        s_d.top = s_q.stack[3'(s_q.sp - 4'h2)];
      end
      else
      begin
        s_d.sp  = 4'h0;
        s_d.top = '0;
      end
    end

    // read data stands only in the cycle after the strobe
    s_d.rdata = ZERO8;
    if (reg_read)
    begin
      case (reg_addr)
        OFS_CTL_MAIN:   s_d.rdata = s_q.ctl_main;
        OFS_CTL_SECOND: s_d.rdata = s_q.ctl_second;
        OFS_CTL_THIRD:  s_d.rdata = s_q.ctl_third;
        OFS_PRIO_TWO:   s_d.rdata = s_q.prio_two & PRIO_TWO_MASK;
        OFS_PRIO_THREE: s_d.rdata = s_q.prio_three & PRIO_THREE_MASK;
        OFS_RESET_CTL:  s_d.rdata = s_q.reset_ctl & RC_MASK;
        OFS_TMR0_LO:    s_d.rdata = s_q.tmr_lo;
        OFS_TMR0_HI:    s_d.rdata = s_q.tmr_hi;
        OFS_TMR0_CTL:   s_d.rdata = s_q.tmr_ctl;
        default:        s_d.rdata = ZERO8;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_q            <= '0;
      s_q.prio_two   <= PRIO_TWO_MASK;
      s_q.prio_three <= PRIO_THREE_MASK;
      s_q.reset_ctl  <= RC_RESET;
      s_q.tmr_ctl    <= T0_CTL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata               = s_q.rdata;
  assign irq_high_req            = s_q.irq_high;
  assign irq_low_req             = s_q.irq_low;
  assign wake_pulse              = s_q.wake;
  assign stack_top               = s_q.top;
  assign stack_depth             = s_q.sp;
  assign shadow_working_register = s_q.sh_working_register;
  assign shadow_status           = s_q.sh_status;
  assign shadow_bank_select_reg  = s_q.sh_bsr;

endmodule

// *** sim/pil_irq_props.sv ***
// concurrent checks on the prioritized interrupt logic ports
`timescale 1ns/10ps
module pil_irq_props
  import pil_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        reset_n,
  input wire logic [pil_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [pil_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic                        reg_write,
  input wire logic                        reg_read,
  input wire logic [pil_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic [3:0]                  ext_pin,
  input wire logic                        irq_ack,
  input wire logic [pil_pkg::PC_W-1:0]    ack_return_pc,
  input wire logic [7:0]                  ack_working_register,
  input wire logic [7:0]                  ack_status,
  input wire logic [7:0]                  ack_bank_select_reg,
  input wire logic                        irq_return,
  input wire logic                        irq_high_req,
  input wire logic                        irq_low_req,
  input wire logic                        wake_pulse,
  input wire logic [pil_pkg::PC_W-1:0]    stack_top,
  input wire logic [pil_pkg::SP_W-1:0]    stack_depth,
  input wire logic [7:0]                  shadow_working_register,
  input wire logic [7:0]                  shadow_status,
  input wire logic [7:0]                  shadow_bank_select_reg
);
  import pil_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_entry;
    irq_ack && !irq_return && stack_depth < 4'h8;
  endsequence
  // write strobe, a gap cycle, then the read of the same place
  sequence s_prio_wr_rd;
    reg_write && reg_addr == OFS_PRIO_TWO ##2 reg_read && reg_addr == OFS_PRIO_TWO;
  endsequence
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_unmapped_zero: assert property (reg_read && reg_addr > OFS_TMR0_CTL |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  a_prio2_mask: assert property (s_prio_wr_rd |=>
      reg_rdata == ($past(reg_wdata, 3) & PRIO_TWO_MASK))
    else $error("second priority bits wrong");
  a_prio3_fixed: assert property (reg_read && reg_addr == OFS_PRIO_THREE |=>
      (reg_rdata & ~PRIO_THREE_MASK) == 8'h00 && reg_rdata[5:4] == 2'h3)
    else $error("third priority fixed bits wrong");
  a_rc_spare: assert property (reg_read && reg_addr == OFS_RESET_CTL |=> !reg_rdata[6])
    else $error("reset control spare bit set");
  a_ack_drop: assert property (irq_ack |=> !irq_high_req && !irq_low_req)
    else $error("request stayed up after entry");
  a_shadow_copy: assert property (irq_ack |=>
      shadow_working_register == $past(ack_working_register)
      && shadow_status == $past(ack_status)
      && shadow_bank_select_reg == $past(ack_bank_select_reg))
    else $error("shadow copy wrong");
  a_stack_push: assert property (s_entry |=> stack_depth == $past(stack_depth) + 4'h1
      && stack_top == $past(ack_return_pc))
    else $error("return pc not pushed");
  a_stack_pop: assert property (irq_return && !irq_ack && stack_depth != 4'h0 |=>
      stack_depth == $past(stack_depth) - 4'h1)
    else $error("stack not popped");
  a_wake_cause: assert property (wake_pulse |-> $past(ext_pin) != $past(ext_pin, 2)
      || $past(ext_pin, 2) != $past(ext_pin, 3))
    else $error("wake without pin edge");
  a_wake_once: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
endmodule

bind pil_irq pil_irq_props u_props (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .ext_pin, .irq_ack, .ack_return_pc, .ack_working_register, .ack_status,
  .ack_bank_select_reg, .irq_return, .irq_high_req, .irq_low_req, .wake_pulse, .stack_top,
  .stack_depth, .shadow_working_register, .shadow_status, .shadow_bank_select_reg);

// *** sim/pil_core_model.sv ***
// core model: takes a pending request after a set delay, returns on command
`timescale 1ns/10ps
module pil_core_model
  import pil_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      irq_high_req,
  input  wire logic                      irq_low_req,
  input  wire logic                      take_en,
  input  wire logic [3:0]                dly,
  input  wire logic                      ret_cmd,
  output logic                           irq_ack,
  output logic                           irq_ack_high,
  output logic      [pil_pkg::PC_W-1:0]  ack_return_pc,
  output logic      [7:0]                ack_working_register,
  output logic      [7:0]                ack_status,
  output logic      [7:0]                ack_bank_select_reg,
  output logic                           irq_return
);
  import pil_pkg::*;
  logic [3:0]      cnt;
  logic [PC_W-1:0] cyc;
  logic [7:0]      saved_w;
  // context lines move every cycle, bank select every second cycle, so a late sample is caught
  assign ack_return_pc        = cyc;
  assign ack_working_register = cyc[7:0];
  assign ack_status           = ~cyc[7:0];
  assign ack_bank_select_reg  = cyc[8:1];
  always_ff @(posedge clk)
  begin
    cyc <= reset_n ? cyc + 21'h1 : 21'h0;
    irq_return <= ret_cmd && reset_n;
    if (irq_ack)
      saved_w <= ack_working_register;
    if (!reset_n || irq_ack || !take_en || !(irq_high_req || irq_low_req))
    begin
      cnt <= 4'h0;
      irq_ack <= 1'h0;
      irq_ack_high <= 1'h0;
    end
    else if (cnt == dly)
    begin
      irq_ack <= 1'h1;
      irq_ack_high <= irq_high_req;
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule

// *** sim/tb.sv ***
// testbench: register, edge, timer, priority and entry checks with a core model
`timescale 1ns/10ps
module tb;
  import pil_pkg::*;
  logic                 clk = 1'h0;
  logic                 reset_n = 1'h0;
  logic [ADDR_W-1:0]    reg_addr = 4'h0;
  logic [DATA_W-1:0]    reg_wdata = 8'h00;
  logic                 reg_write = 1'h0;
  logic                 reg_read = 1'h0;
  logic [3:0]           ext_pin = 4'h0;
  logic [3:0]           portb_high_in = 4'h0;
  logic [7:0]           periph_pend_two = 8'h00;
  logic [7:0]           periph_pend_three = 8'h00;
  logic                 wdt_expire = 1'h0;
  logic                 wdt_clear = 1'h0;
  logic                 reset_instr = 1'h0;
  logic                 sleep_enter = 1'h0;
  logic                 take_en = 1'h0;
  logic [3:0]           dly = 4'h3;
  logic                 ret_cmd = 1'h0;
  logic [DATA_W-1:0]    reg_rdata;
  logic                 irq_ack, irq_ack_high, irq_return, irq_high_req, irq_low_req, wake_pulse;
  logic [PC_W-1:0]      ack_return_pc, stack_top;
  logic [7:0]           ack_working_register, ack_status, ack_bank_select_reg;
  logic [7:0]           shadow_working_register, shadow_status, shadow_bank_select_reg;
  logic [SP_W-1:0]      stack_depth;
  logic [7:0]           rv [10] = '{8'h00, 8'h00, 8'h00, 8'hce, 8'h36, 8'h3c, 8'h00, 8'h00,
                                    8'h40, 8'h00};
  int                   n_errors = 0;
  int                   compares = 0;
  always #5 clk = ~clk;
  pil_irq i_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .ext_pin, .portb_high_in, .periph_pend_two, .periph_pend_three, .sleep_enter,
    .wdt_expire, .wdt_clear, .reset_instr, .irq_ack, .irq_ack_high,
    .ack_return_pc, .ack_working_register, .ack_status, .ack_bank_select_reg, .irq_return,
    .irq_high_req, .irq_low_req, .wake_pulse, .stack_top, .stack_depth,
    .shadow_working_register, .shadow_status, .shadow_bank_select_reg);
  pil_core_model i_core (.clk, .reset_n, .irq_high_req, .irq_low_req, .take_en, .dly, .ret_cmd,
    .irq_ack, .irq_ack_high, .ack_return_pc, .ack_working_register, .ack_status,
    .ack_bank_select_reg, .irq_return);
  task automatic close_out();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'h0;
    #1 cmp(reg_rdata, e);
    @(posedge clk);
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? irq_high_req : (k == 1 ? irq_low_req : wake_pulse);
  endfunction
  // bounded wait; a timeout ends the run
  task automatic wt(input int k);
    for (int i = 0; i < 20 && sig(k) !== 1'h1; i++)
      @(posedge clk);
    cmp({7'h00, sig(k)}, 8'h01);
    if (sig(k) !== 1'h1)
      close_out();
  endtask
  task automatic ret();
    ret_cmd <= 1'h1;
    @(posedge clk);
    ret_cmd <= 1'h0;
    tick(3);
  endtask
  initial
  begin
    tick(12);
    reset_n <= 1'h1;
    @(posedge clk);
    for (int a = 0; a < 10; a++)
      rd(a[3:0], rv[a]);
    wr(OFS_PRIO_TWO, 8'hff);
    rd(OFS_PRIO_TWO, 8'hce);
    wr(OFS_PRIO_THREE, 8'h00);
    rd(OFS_PRIO_THREE, 8'h30);
    wr(OFS_RESET_CTL, 8'h00);
    rd(OFS_RESET_CTL, 8'h0c);
    wr(OFS_RESET_CTL, 8'hff);
    rd(OFS_RESET_CTL, 8'hbf);
    reset_instr <= 1'h1;
    wdt_expire <= 1'h1;
    @(posedge clk);
    reset_instr <= 1'h0;
    wdt_expire <= 1'h0;
    rd(OFS_RESET_CTL, 8'ha7);
    wdt_clear <= 1'h1;
    @(posedge clk);
    wdt_clear <= 1'h0;
    rd(OFS_RESET_CTL, 8'haf);
    // rising select, falling select, then the opposite edge of each
    for (int p = 0; p < 4; p++)
    begin
      // global enables on, so only the cleared source enables hold requests back
      wr(OFS_CTL_MAIN, 8'hc0);
      wr(OFS_CTL_THIRD, 8'h00);
      wr(OFS_CTL_SECOND, (p == 1 || p == 2) ? 8'h00 : 8'h78);
      ext_pin <= p[0] ? 4'h0 : 4'hf;
      tick(3);
      rd(OFS_CTL_MAIN, p < 2 ? 8'hc2 : 8'hc0);
      rd(OFS_CTL_THIRD, p < 2 ? 8'h07 : 8'h00);
      cmp({6'h00, irq_high_req, irq_low_req}, 8'h00);
    end
    wr(OFS_RESET_CTL, 8'h00);
    wr(OFS_CTL_MAIN, 8'h10);
    ext_pin <= 4'h1;
    tick(4);
    cmp({6'h00, irq_high_req, irq_low_req}, 8'h00);
    take_en <= 1'h1;
    wr(OFS_CTL_MAIN, 8'h92);
    wt(0);
    tick(8);
    cmp({4'h0, stack_depth}, 8'h01);
    cmp(shadow_working_register, i_core.saved_w);
    wr(OFS_CTL_MAIN, 8'h90);
    ret();
    cmp({4'h0, stack_depth}, 8'h00);
    wr(OFS_CTL_MAIN, 8'h80);
    periph_pend_two <= 8'h02;
    tick(4);
    cmp({6'h00, irq_high_req, irq_low_req}, 8'h00);
    wr(OFS_CTL_MAIN, 8'hc0);
    wt(0);
    tick(8);
    cmp({4'h0, stack_depth}, 8'h01);
    periph_pend_two <= 8'h00;
    ret();
    wr(OFS_RESET_CTL, 8'h80);
    take_en <= 1'h0;
    wr(OFS_TMR0_LO, 8'hfe);
    wr(OFS_CTL_MAIN, 8'he0);
    wr(OFS_TMR0_CTL, 8'hc0);
    wt(1);
    cmp({7'h00, irq_high_req}, 8'h00);
    take_en <= 1'h1;
    tick(8);
    wr(OFS_TMR0_CTL, 8'h40);
    wr(OFS_CTL_MAIN, 8'hf0);
    ext_pin <= 4'h0;
    tick(2);
    ext_pin <= 4'h1;
    wt(0);
    tick(8);
    cmp({4'h0, stack_depth}, 8'h02);
    take_en <= 1'h0;
    wr(OFS_CTL_MAIN, 8'h00);
    ret();
    ret();
    for (int h = 0; h < 2; h++)
    begin
      wr(OFS_TMR0_CTL, 8'h00);
      wr(OFS_TMR0_HI, h ? 8'hff : 8'h00);
      wr(OFS_TMR0_LO, 8'hfe);
      wr(OFS_TMR0_CTL, 8'h80);
      tick(4);
      rd(OFS_CTL_MAIN, h ? 8'h04 : 8'h00);
    end
    wr(OFS_TMR0_CTL, 8'h00);
    wr(OFS_CTL_MAIN, 8'h00);
    portb_high_in <= 4'h8;
    tick(3);
    rd(OFS_CTL_MAIN, 8'h01);
    wr(OFS_CTL_MAIN, 8'hc9);
    wt(1);
    wr(OFS_CTL_MAIN, 8'h00);
    wr(OFS_CTL_THIRD, 8'h08);
    sleep_enter <= 1'h1;
    @(posedge clk);
    sleep_enter <= 1'h0;
    ext_pin <= 4'h3;
    wt(2);
    tick(3);
    cmp({6'h00, irq_high_req, irq_low_req}, 8'h00);
    wr(OFS_CTL_MAIN, 8'hc0);
    wt(1);
    wr(OFS_CTL_THIRD, 8'h49);
    wt(0);
    wr(OFS_CTL_THIRD, 8'h00);
    periph_pend_three <= 8'h02;
    wt(1);
    cmp({7'h00, irq_high_req}, 8'h00);
    periph_pend_three <= 8'h20;
    wt(0);
    close_out();
  end
endmodule
